/* File: rtl/dcd_params.svh */
`ifndef DCD_PARAMS_SVH
`define DCD_PARAMS_SVH

// register byte offsets
`define DCD_OFS_CH2_CODE 8'h00
`define DCD_OFS_CH3_CODE 8'h04
`define DCD_OFS_CTRL 8'h08
`define DCD_OFS_STOP 8'h0C
`define DCD_OFS_STATUS 8'h10

// control field positions
`define DCD_CTRL_OE3_BIT 7
`define DCD_CTRL_OE2_BIT 6
`define DCD_CTRL_JE_BIT 5
`define DCD_CTRL_RSVD_VAL 5'h1F

// status field positions
`define DCD_STAT_VALID2_BIT 0
`define DCD_STAT_VALID3_BIT 1
`define DCD_STAT_BUSY2_BIT 2
`define DCD_STAT_BUSY3_BIT 3
`define DCD_STAT_CONV2_BIT 4
`define DCD_STAT_CONV3_BIT 5
`define DCD_STAT_STBY_BIT 6

// reset values
`define DCD_CODE_RESET 8'h00
`define DCD_OE_RESET 1'b0
`define DCD_JE_RESET 1'b0
`define DCD_STOP_RESET 1'b1

// bus constants
`define DCD_HSIZE_WORD 3'h2
`define DCD_ADDR_W 8

// timing
`define DCD_CLK_PERIOD_NS 50
`define DCD_CONV_TIME_NS 10000
`define DCD_CONV_CYCLES (`DCD_CONV_TIME_NS / `DCD_CLK_PERIOD_NS)
`define DCD_CNT_W 8

`endif

/* File: rtl/dcd_pkg.sv */
package dcd_pkg;

  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_conv = 3'h2,
    st_hold = 3'h4
  } dcd_conv_state_t;

  typedef enum logic [2:0] {
    ph_idle = 3'h1,
    ph_write = 3'h2,
    ph_read = 3'h4
  } dcd_bus_phase_t;

endpackage

/* File: rtl/dcd_conv_timer.sv */
`timescale 1ns/1ps
`include "dcd_params.svh"

module dcd_conv_timer #(
  parameter int CYCLES = `DCD_CONV_CYCLES
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic restart_in,
  input wire logic freeze_in,
  output logic busy_out,
  output logic valid_out
);

  localparam int W = `DCD_CNT_W;
  localparam logic [W-1:0] LOAD = W'(CYCLES - 1);

  dcd_pkg::dcd_conv_state_t state_r;
  dcd_pkg::dcd_conv_state_t state_nxt;
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (!freeze_in)
    begin
      unique case (state_r)
        dcd_pkg::st_idle:
        begin
          if (run_in)
          begin
            state_nxt = dcd_pkg::st_conv;
            cnt_nxt = LOAD;
          end
        end
        dcd_pkg::st_conv:
        begin
          if (!run_in)
            state_nxt = dcd_pkg::st_idle;
          else if (restart_in)
            cnt_nxt = LOAD;
          else if (cnt_r == '0)
            state_nxt = dcd_pkg::st_hold;
          else
            cnt_nxt = cnt_r - 1'b1;
        end
        dcd_pkg::st_hold:
        begin
          if (!run_in)
            state_nxt = dcd_pkg::st_idle;
          else if (restart_in)
          begin
            state_nxt = dcd_pkg::st_conv;
            cnt_nxt = LOAD;
          end
        end
        default:
          state_nxt = dcd_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r <= dcd_pkg::st_idle;
      cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign busy_out = (state_r == dcd_pkg::st_conv);
  assign valid_out = (state_r == dcd_pkg::st_hold);

endmodule

/* File: rtl/dcd_dac_ctrl.sv */
`timescale 1ns/1ps
`include "dcd_params.svh"

// Contract
// - two 8-bit read/write channel code registers
// - enabled channel converts its code continuously
// - bit 7 enables channel 3, resets 0
// - bit 6 enables channel 2, resets 0
// - bit 5 ties conversions together, resets 0
// - output gated by own enable bit, valid result and module stop
// - independent mode: convert only enabled channels
// - joint mode: channel 2 enable starts both
// - bits 4 to 0 read one, ignore writes
// - enabling starts conversion, result after delay
// - result holds until rewrite or disable
// - code rewrite restarts conversion at once; a rewrite during standby does not restart the timer
// - raw 8-bit code goes to converter
// - module stop halts converter after reset
// - standby holds output while conversion enabled

module dcd_dac_ctrl (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic standby_in,
  output logic [7:0] ch2_code_out,
  output logic [7:0] ch3_code_out,
  output logic ch2_conv_en_out,
  output logic ch3_conv_en_out,
  output logic ch2_analog_en_out,
  output logic ch3_analog_en_out,
  output logic ch2_valid_out,
  output logic ch3_valid_out
);

  localparam int AW = `DCD_ADDR_W;

  ////////////////////////////////////////////////////////////////////////
  // bus phase tracking

  dcd_pkg::dcd_bus_phase_t phase_r;
  dcd_pkg::dcd_bus_phase_t phase_nxt;
  logic [AW-1:0] addr_r;
  logic word_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;

  wire addr_take;
  wire take_write;
  wire take_read;

  assign addr_take = hsel_in & htrans_in[1] & hready_in;
  assign take_write = addr_take & hwrite_in;
  assign take_read = addr_take & ~hwrite_in;

  always_comb
  begin
    phase_nxt = dcd_pkg::ph_idle;
    if (take_write)
      phase_nxt = dcd_pkg::ph_write;
    else if (take_read)
      phase_nxt = dcd_pkg::ph_read;
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_r <= dcd_pkg::ph_idle;
      addr_r <= '0;
      word_r <= 1'b0;
    end
    else
    begin
      phase_r <= phase_nxt;
      if (addr_take)
      begin
        addr_r <= haddr_in[AW-1:0];
        word_r <= (hsize_in == `DCD_HSIZE_WORD);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register decode

  logic oe2_r;
  logic oe3_r;
  logic je_r;
  logic stop_r;
  logic [7:0] code_r [2];

  wire wr_go;
  wire hit_ch2;
  wire hit_ch3;
  wire hit_ctrl;
  wire hit_stop;
  wire hit_stat;
  wire wr_ctrl;
  wire wr_stop;
  wire [1:0] wr_code;

  assign hit_ch2 = (addr_r == `DCD_OFS_CH2_CODE);
  assign hit_ch3 = (addr_r == `DCD_OFS_CH3_CODE);
  assign hit_ctrl = (addr_r == `DCD_OFS_CTRL);
  assign hit_stop = (addr_r == `DCD_OFS_STOP);
  assign hit_stat = (addr_r == `DCD_OFS_STATUS);

  // stopped module ignores all writes but the stop register
  assign wr_go = (phase_r == dcd_pkg::ph_write) & word_r;
  assign wr_code[0] = wr_go & hit_ch2 & ~stop_r;
  assign wr_code[1] = wr_go & hit_ch3 & ~stop_r;
  assign wr_ctrl = wr_go & hit_ctrl & ~stop_r;
  assign wr_stop = wr_go & hit_stop;

  ////////////////////////////////////////////////////////////////////////
  // control and stop registers

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      oe3_r <= `DCD_OE_RESET;
      oe2_r <= `DCD_OE_RESET;
      je_r <= `DCD_JE_RESET;
    end
    else if (wr_ctrl)
    begin
      oe3_r <= hwdata_in[`DCD_CTRL_OE3_BIT];
      oe2_r <= hwdata_in[`DCD_CTRL_OE2_BIT];
      je_r <= hwdata_in[`DCD_CTRL_JE_BIT];
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      stop_r <= `DCD_STOP_RESET;
    else if (wr_stop)
      stop_r <= hwdata_in[0];
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion enables

  wire any_oe;
  wire [1:0] oe;
  wire [1:0] conv_en;

  assign oe[0] = oe2_r;
  assign oe[1] = oe3_r;
  assign any_oe = oe2_r | oe3_r;

  // joint mode with channel 3 enable set is treated as both running
  assign conv_en[0] = ~stop_r & (je_r ? any_oe : oe2_r);
  assign conv_en[1] = ~stop_r & (je_r ? any_oe : oe3_r);

  ////////////////////////////////////////////////////////////////////////
  // per-channel code, timer and converter drive

  wire [1:0] busy;
  wire [1:0] valid;
  logic [7:0] code_out_r [2];
  logic [1:0] conv_en_out_r;
  logic [1:0] analog_en_r;
  logic [1:0] valid_out_r;

  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
      if (rst_in)
        code_r[i] <= `DCD_CODE_RESET;
      else if (wr_code[i])
        code_r[i] <= hwdata_in[7:0];
    end

    dcd_conv_timer u_timer (
      .clk_in(mclk_in),
      .rst_in(rst_in),
      .run_in(conv_en[i]),
      .restart_in(wr_code[i]),
      .freeze_in(standby_in),
      .busy_out(busy[i]),
      .valid_out(valid[i])
    );

    // standby freezes the drive at its present value
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
      if (rst_in)
      begin
        code_out_r[i] <= `DCD_CODE_RESET;
        conv_en_out_r[i] <= 1'b0;
        analog_en_r[i] <= 1'b0;
        valid_out_r[i] <= 1'b0;
      end
      else if (!standby_in)
      begin
        code_out_r[i] <= code_r[i];
        conv_en_out_r[i] <= conv_en[i];
        analog_en_r[i] <= oe[i] & valid[i] & ~stop_r;
        valid_out_r[i] <= valid[i];
      end
    end
  end

  assign ch2_code_out = code_out_r[0];
  assign ch3_code_out = code_out_r[1];
  assign ch2_conv_en_out = conv_en_out_r[0];
  assign ch3_conv_en_out = conv_en_out_r[1];
  assign ch2_analog_en_out = analog_en_r[0];
  assign ch3_analog_en_out = analog_en_r[1];
  assign ch2_valid_out = valid_out_r[0];
  assign ch3_valid_out = valid_out_r[1];

  ////////////////////////////////////////////////////////////////////////
  // read path

  wire [7:0] ctrl_rd;
  wire [7:0] stat_rd;
  wire [31:0] rd_live;
  wire [31:0] rd_value;

  assign ctrl_rd = {oe3_r, oe2_r, je_r, `DCD_CTRL_RSVD_VAL};

  assign stat_rd[`DCD_STAT_VALID2_BIT] = valid[0];
  assign stat_rd[`DCD_STAT_VALID3_BIT] = valid[1];
  assign stat_rd[`DCD_STAT_BUSY2_BIT] = busy[0];
  assign stat_rd[`DCD_STAT_BUSY3_BIT] = busy[1];
  assign stat_rd[`DCD_STAT_CONV2_BIT] = conv_en[0];
  assign stat_rd[`DCD_STAT_CONV3_BIT] = conv_en[1];
  assign stat_rd[`DCD_STAT_STBY_BIT] = standby_in;
  assign stat_rd[7] = 1'b0;

  assign rd_live = hit_ch2 ? {24'h000000, code_r[0]} :
                   hit_ch3 ? {24'h000000, code_r[1]} :
                   hit_ctrl ? {24'h000000, ctrl_rd} :
                   hit_stat ? {24'h000000, stat_rd} :
                   32'h00000000;

  // only the stop register answers while stopped
  assign rd_value = hit_stop ? {31'h00000000, stop_r} :
                    (stop_r ? 32'h00000000 : rd_live);

  // reads take one wait state so a write just before is seen
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      hrdata_r <= 32'h00000000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
    else
    begin
      hresp_r <= 1'b0;
      if (take_read)
        hreadyout_r <= 1'b0;
      else if (phase_r == dcd_pkg::ph_read)
      begin
        hreadyout_r <= 1'b1;
        hrdata_r <= rd_value;
      end
    end
  end

  assign hrdata_out = hrdata_r;
  assign hreadyout_out = hreadyout_r;
  assign hresp_out = hresp_r;

endmodule

/* File: testbench/dcd_dac_ctrl_assertions.sv */
`timescale 1ns/1ps
module dcd_dac_ctrl_checker (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic standby_in,
  input wire logic [7:0] ch2_code_out,
  input wire logic ch2_conv_en_out,
  input wire logic ch2_valid_out,
  input wire logic ch3_valid_out,
  input wire logic ch2_analog_en_out,
  input wire logic ch3_analog_en_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  wire logic taken = hsel_in & htrans_in[1] & hready_in;
  ////////////////////////////////////////
  property p_gate;
    !(ch2_analog_en_out & !ch2_valid_out) && !(ch3_analog_en_out & !ch3_valid_out);
  endproperty
  a_gate: assert property (p_gate)
    else $error("analog enable without valid result");
  property p_settle;
    $rose(ch2_valid_out) |-> $stable(ch2_code_out);
  endproperty
  a_settle: assert property (p_settle)
    else $error("valid raised while code moving");
  property p_start;
    $rose(ch2_conv_en_out) |-> !ch2_valid_out [*8];
  endproperty
  a_start: assert property (p_start)
    else $error("valid too soon after enable");
  property p_drop;
    $fell(ch2_conv_en_out) |-> ##[0:2] !ch2_valid_out;
  endproperty
  a_drop: assert property (p_drop)
    else $error("valid kept after conversion off");
  property p_restart;
    $changed(ch2_code_out) |-> ##[0:3] !ch2_valid_out;
  endproperty
  a_restart: assert property (p_restart)
    else $error("new code did not restart conversion");
  property p_hold;
    standby_in && $past(standby_in) |->
      $stable({ch2_analog_en_out, ch3_analog_en_out, ch2_code_out});
  endproperty
  a_hold: assert property (p_hold)
    else $error("output moved in standby");
  property p_rd;
    taken && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read wait state wrong");
  property p_wr;
    taken && hwrite_in |=> hreadyout_out;
  endproperty
  a_wr: assert property (p_wr)
    else $error("write stalled");
endmodule

bind dcd_dac_ctrl dcd_dac_ctrl_checker u_dcd_dac_ctrl_checker (
  .mclk_in(mclk_in), .rst_in(rst_in), .hsel_in(hsel_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hreadyout_out(hreadyout_out), .standby_in(standby_in),
  .ch2_code_out(ch2_code_out), .ch2_conv_en_out(ch2_conv_en_out),
  .ch2_valid_out(ch2_valid_out), .ch3_valid_out(ch3_valid_out),
  .ch2_analog_en_out(ch2_analog_en_out),
  .ch3_analog_en_out(ch3_analog_en_out));

/* File: testbench/dcd_dac_ctrl_tb_top.sv */
`timescale 1ns/1ps
`include "dcd_params.svh"
module dcd_dac_ctrl_tb_top;
  logic mclk_in = 1'h0, rst_in = 1'h1, hsel_in = 1'h0, hwrite_in = 1'h0;
  logic standby_in = 1'h0;
  logic [1:0] htrans_in = 2'h0;
  logic [2:0] hsize_in = 3'h2;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, q;
  logic hreadyout_out, hresp_out, ch2_conv_en_out, ch3_conv_en_out;
  logic ch2_analog_en_out, ch3_analog_en_out, ch2_valid_out, ch3_valid_out;
  logic [7:0] ch2_code_out, ch3_code_out;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, n;
  dcd_dac_ctrl u_dcd_dac_ctrl (.mclk_in(mclk_in), .rst_in(rst_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .standby_in(standby_in), .ch2_code_out(ch2_code_out),
    .ch3_code_out(ch3_code_out), .ch2_conv_en_out(ch2_conv_en_out),
    .ch3_conv_en_out(ch3_conv_en_out),
    .ch2_analog_en_out(ch2_analog_en_out),
    .ch3_analog_en_out(ch3_analog_en_out),
    .ch2_valid_out(ch2_valid_out), .ch3_valid_out(ch3_valid_out));
  initial forever #25 mclk_in = ~mclk_in;
  ////////////////////////////////////////
  task finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      finish_test;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one single word transfer, entered just after a rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel_in <= 1'h1;
    htrans_in <= 2'h2;
    hwrite_in <= w;
    haddr_in <= {24'h0, a};
    do @(negedge mclk_in); while (hreadyout_out !== 1'h1);
    @(posedge mclk_in);
    hsel_in <= 1'h0;
    htrans_in <= 2'h0;
    hwdata_in <= {24'h0, d};
    do @(negedge mclk_in); while (hreadyout_out !== 1'h1);
    q = hrdata_out;
    chk(hresp_out, 1'h0);
    @(posedge mclk_in);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'h1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 8'h0);
    chk(q, e);
  endtask
  task wait_ch2;
    n = 0;
    while (ch2_analog_en_out !== 1'h1 && n < 400)
    begin
      @(negedge mclk_in);
      n++;
    end
    @(posedge mclk_in);
  endtask
  ////////////////////////////////////////
  task t_stop;
    rd(`DCD_OFS_CTRL, 32'h0);
    wr(`DCD_OFS_CH2_CODE, 8'hA5);
    wr(`DCD_OFS_STOP, 8'h0);
    rd(`DCD_OFS_CH2_CODE, 32'h0);
  endtask
  task t_regs;
    rd(`DCD_OFS_CTRL, 32'h1F);
    wr(`DCD_OFS_CH2_CODE, 8'hA5);
    wr(`DCD_OFS_CH3_CODE, 8'h5A);
    rd(`DCD_OFS_CH2_CODE, 32'hA5);
    rd(`DCD_OFS_CH3_CODE, 32'h5A);
    chk(ch3_code_out, 8'h5A);
    rd(8'h14, 32'h0);
  endtask
  task t_modes;
    logic [7:0] v [6];
    logic [1:0] e [6];
    v = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h20, 8'h60};
    e = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h3};
    for (int i = 0; i < 6; i++)
    begin
      wr(`DCD_OFS_CTRL, v[i]);
      rd(`DCD_OFS_CTRL, {24'h0, v[i] | 8'h1F});
      chk({ch3_conv_en_out, ch2_conv_en_out}, e[i]);
    end
    wr(`DCD_OFS_CTRL, 8'h00);
  endtask
  task t_conv;
    wr(`DCD_OFS_CTRL, 8'h40);
    repeat (2) @(negedge mclk_in);
    chk({ch3_conv_en_out, ch2_conv_en_out}, 2'h1);
    chk(ch2_analog_en_out, 1'h0);
    wait_ch2;
    chk(n >= 199 && n <= 210, 1'h1);
    chk(ch2_code_out, 8'hA5);
    chk(ch3_analog_en_out, 1'h0);
    repeat (30) @(negedge mclk_in);
    chk(ch2_analog_en_out, 1'h1);
    @(posedge mclk_in);
    rd(`DCD_OFS_STATUS, 32'h11);
  endtask
  task t_restart;
    wr(`DCD_OFS_CH2_CODE, 8'h3C);
    repeat (3) @(negedge mclk_in);
    chk(ch2_valid_out, 1'h0);
    wait_ch2;
    chk(n >= 196 && n <= 210, 1'h1);
    chk(ch2_code_out, 8'h3C);
  endtask
  task t_standby;
    standby_in <= 1'h1;
    repeat (50) @(negedge mclk_in);
    chk({ch2_analog_en_out, ch2_valid_out}, 2'h3);
    @(posedge mclk_in);
    standby_in <= 1'h0;
    wr(`DCD_OFS_CTRL, 8'h00);
    repeat (3) @(negedge mclk_in);
    chk(ch2_analog_en_out, 1'h0);
    @(posedge mclk_in);
  endtask
  initial
  begin
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'h0;
    t_stop;
    t_regs;
    t_modes;
    t_conv;
    t_restart;
    t_standby;
    finish_test;
  end
endmodule
